// [design/rsc_reset_suspend_control.sv]
// Reset and suspend sequencer of a bus-attached card controller.
// Assumes i_clk is the bus clock and all functional inputs are synchronous to it.
`timescale 1ns/1ps
module rsc_reset_suspend_control
(
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Reset pins and suspend mode
    input wire rsc_pkg::rsc_ctrl_type i_ctrl,
    // Functional requests
    input wire logic i_cfg_we,
    input wire logic [rsc_pkg::CFG_W-1:0] i_cfg_data,
    input wire logic i_pme_event,
    input wire logic i_pme_clear,
    // Status: output enable, function enable, wake context, configuration
    output rsc_pkg::rsc_status_type o_status
);

    // ************************************************************
    // Reset gating
    // ************************************************************
    logic cold_hit;
    logic bus_hit;
    logic core_arst_n;
    logic pme_arst_n;
    logic oe_arst_n;
    logic core_rst_n;
    logic pme_rst_n;
    logic oe_rst_n;

    // Suspend gates both pins before the core flops and the cold pin before the wake-context flops, so a reset pulse that
    // arrives while suspended never disturbs the held state.
    // suspend shields resets
    assign cold_hit = !i_ctrl.cold_global_reset_n && !i_ctrl.suspend_en;
    assign bus_hit = !i_ctrl.bus_reset_in_n && !i_ctrl.suspend_en;

    // The power-on reset is never shielded, so a cold start always clears everything.
    // core clear
    assign core_arst_n = i_rstn && !cold_hit && !bus_hit;

    assign pme_arst_n = i_rstn && !cold_hit;

    // Output float is not shielded by suspend, so it sees the raw pins.
    assign oe_arst_n = i_rstn && i_ctrl.cold_global_reset_n && i_ctrl.bus_reset_in_n
        && !i_ctrl.suspend_en;

    // Three domains release apart because the wake context and the output float
    // answer to different reset sources; each needs its own clean release edge.
    // synchronous release
    rsc_reset_sync u_core_sync
    (
        .i_clk(i_clk),
        .i_arst_n(core_arst_n),
        .o_rst_n(core_rst_n)
    );

    rsc_reset_sync u_pme_sync
    (
        .i_clk(i_clk),
        .i_arst_n(pme_arst_n),
        .o_rst_n(pme_rst_n)
    );

    rsc_reset_sync u_oe_sync
    (
        .i_clk(i_clk),
        .i_arst_n(oe_arst_n),
        .o_rst_n(oe_rst_n)
    );

    // ************************************************************
    // Core state and configuration
    // ************************************************************
    rsc_pkg::rsc_state_type state;
    rsc_pkg::rsc_state_type next_state;
    logic [rsc_pkg::CFG_W-1:0] cfg;
    logic [rsc_pkg::CFG_W-1:0] next_cfg;
    logic func_en;
    logic next_func_en;

    // The wake state costs one cycle after release, which keeps the pins floating
    // until the core has left its default state cleanly.
    always_comb
    begin
        next_state = state;
        next_cfg = cfg;
        next_func_en = 1'h0;
        unique case (state)
            rsc_pkg::ST_RESET:
            begin
                next_state = rsc_pkg::ST_WAKE;
            end
            rsc_pkg::ST_WAKE:
            begin
                next_state = i_ctrl.suspend_en ? rsc_pkg::ST_SUSPEND : rsc_pkg::ST_RUN;
            end
            rsc_pkg::ST_RUN:
            begin
                if (i_ctrl.suspend_en)
                begin
                    next_state = rsc_pkg::ST_SUSPEND;
                end
                else
                begin
                    next_func_en = 1'h1;
                    if (i_cfg_we)
                    begin
                        next_cfg = i_cfg_data;
                    end
                end
            end
            rsc_pkg::ST_SUSPEND:
            begin
                if (!i_ctrl.suspend_en)
                begin
                    next_state = rsc_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            state <= rsc_pkg::ST_RESET;
            cfg <= rsc_pkg::CFG_RESET;
            func_en <= 1'h0;
        end
        else
        begin
            state <= next_state;
            cfg <= next_cfg;
            func_en <= next_func_en;
        end
    end

    // ************************************************************
    // Wake-event context
    // ************************************************************
    logic pme_pending;
    logic next_pme_pending;

    // A new event beats a clear in the same cycle, so no wake is ever lost.
    // The clear is taken only while running; under any reset or in suspend the
    // state is elsewhere, except in the first suspend cycle, when the state is still run and a stray clear does wipe a pending wake.
    always_comb
    begin
        next_pme_pending = pme_pending;
        if (i_pme_clear && state == rsc_pkg::ST_RUN)
        begin
            next_pme_pending = 1'h0;
        end
        if (i_pme_event)
        begin
            next_pme_pending = 1'h1;
        end
    end

    always_ff @(posedge i_clk or negedge pme_rst_n)
    begin
        if (!pme_rst_n)
        begin
            pme_pending <= 1'h0;
        end
        else
        begin
            pme_pending <= next_pme_pending;
        end
    end

    // ************************************************************
    // Output enable
    // ************************************************************
    logic out_en;
    logic next_out_en;

    // Enabling only from the run state keeps pins floating through the settle cycle.
    always_comb
    begin
        next_out_en = (state == rsc_pkg::ST_RUN) && !i_ctrl.suspend_en;
    end

    always_ff @(posedge i_clk or negedge oe_rst_n)
    begin
        if (!oe_rst_n)
        begin
            out_en <= 1'h0;
        end
        else
        begin
            out_en <= next_out_en;
        end
    end

    // Each status field comes straight from its own register, so no gate sits
    // between a flop and a pin and no glitch can reach the far side.
    assign o_status.out_en = out_en;
    assign o_status.func_en = func_en;
    assign o_status.pme_pending = pme_pending;
    assign o_status.cfg = cfg;

endmodule

// [design/rsc_pkg.sv]
// Package for the reset and suspend controller: states, carriers, widths, reset values.
// Assumes one bus clock drives every register of the block.
package rsc_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;
    localparam logic SYNC_RESET = 1'h0;
    localparam logic SYNC_RELEASE = 1'h1;

    // ************************************************************
    // Core sequence states, Gray coded along reset, wake, run, suspend
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_WAKE = 2'h1,
        ST_RUN = 2'h3,
        ST_SUSPEND = 2'h2
    } rsc_state_type;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic out_en;
        logic func_en;
        logic pme_pending;
        logic [CFG_W-1:0] cfg;
    } rsc_status_type;

    typedef struct packed {
        logic cold_global_reset_n;
        logic bus_reset_in_n;
        logic suspend_en;
    } rsc_ctrl_type;

endpackage

// [design/rsc_reset_sync.sv]
// Reset synchroniser: asserts at once, releases on the second rising clock edge.
// Assumes the asynchronous input may change at any time relative to the clock.
`timescale 1ns/1ps
module rsc_reset_sync
(
    // Clock and asynchronous reset request
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Synchronised reset
    output logic o_rst_n
);

    logic [rsc_pkg::SYNC_STAGES-1:0] chain;
    logic [rsc_pkg::SYNC_STAGES-1:0] next_chain;

    always_comb
    begin
        next_chain = {chain[rsc_pkg::SYNC_STAGES-2:0], rsc_pkg::SYNC_RELEASE};
    end

    // The first stage feeds only the second, so a metastable release stays contained.
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            chain <= {rsc_pkg::SYNC_STAGES{rsc_pkg::SYNC_RESET}};
        end
        else
        begin
            chain <= next_chain;
        end
    end

    assign o_rst_n = chain[rsc_pkg::SYNC_STAGES-1];

endmodule

// [bench/rsc_checker.sv]
// Checker: reset, suspend and write timing seen at the sequencer ports.
// Assumes the bus clock and power-on reset of the bound design.
`timescale 1ns/1ps
module rsc_checker
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire rsc_pkg::rsc_ctrl_type i_ctrl,
    input wire logic i_cfg_we,
    input wire logic [rsc_pkg::CFG_W-1:0] i_cfg_data,
    input wire logic i_pme_clear,
    input wire rsc_pkg::rsc_status_type o_status
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    cold_clear_a: assert property (!i_ctrl.cold_global_reset_n && !i_ctrl.suspend_en
        |-> o_status == '0) else $error("cold reset left state");
    bus_float_a: assert property (!i_ctrl.bus_reset_in_n
        |-> !o_status.out_en) else $error("outputs driven in bus reset");
    bus_idle_a: assert property (!i_ctrl.bus_reset_in_n && !i_ctrl.suspend_en
        |-> !o_status.func_en && o_status.cfg == '0) else $error("active in bus reset");
    pme_kept_a: assert property (!i_ctrl.bus_reset_in_n && i_ctrl.cold_global_reset_n
        && $past(o_status.pme_pending) && !$past(i_pme_clear) |-> o_status.pme_pending)
        else $error("wake context lost");
    release_run_a: assert property ($rose(i_ctrl.bus_reset_in_n)
        && i_ctrl.cold_global_reset_n && !i_ctrl.suspend_en
        |-> !o_status.func_en [*2] ##[1:6] o_status.func_en && o_status.out_en)
        else $error("bad start after reset");
    susp_float_a: assert property (i_ctrl.suspend_en |-> !o_status.out_en)
        else $error("outputs driven in suspend");
    susp_keep_a: assert property (i_ctrl.suspend_en && $past(i_ctrl.suspend_en)
        |-> $stable(o_status.cfg)) else $error("cfg changed in suspend");
    cfg_write_a: assert property (i_cfg_we && o_status.func_en && !i_ctrl.suspend_en
        |=> o_status.cfg == $past(i_cfg_data)) else $error("cfg write lost");
endmodule
bind rsc_reset_suspend_control rsc_checker rsc_checker_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_ctrl(i_ctrl), .i_cfg_we(i_cfg_we), .i_cfg_data(i_cfg_data),
    .i_pme_clear(i_pme_clear), .o_status(o_status));

// [bench/rsc_host_model.sv]
// Host reset logic: drives both reset pins and suspend mode.
// Assumes one bench process calls its task.
`timescale 1ns/1ps
module rsc_host_model
(
    // Bus clock
    input wire logic i_clk,
    // Reset pins and suspend
    output rsc_pkg::rsc_ctrl_type o_ctrl
);
    initial o_ctrl = '{1'h0, 1'h1, 1'h0};
    task automatic drive(input logic c, input logic b, input logic s);
        @(negedge i_clk);
        o_ctrl = '{c, b, s};
    endtask
endmodule

// [bench/rsc_reset_suspend_control_tb_top.sv]
// Bench of the reset and suspend sequencer with a host reset model.
// Assumes a 200 MHz bus clock; notes are queued and checked by a monitor.
`timescale 1ns/1ps
module rsc_reset_suspend_control_tb_top;
    logic i_clk;
    logic i_rstn;
    rsc_pkg::rsc_ctrl_type ctrl;
    logic i_cfg_we;
    logic [rsc_pkg::CFG_W-1:0] i_cfg_data;
    logic [rsc_pkg::CFG_W-1:0] d;
    logic i_pme_event;
    logic i_pme_clear;
    rsc_pkg::rsc_status_type o_status;
    rsc_pkg::rsc_status_type exp_q[$];
    int bad_count;
    int total_checks;
    rsc_host_model rsc_host_model_inst (.i_clk(i_clk), .o_ctrl(ctrl));
    rsc_reset_suspend_control rsc_reset_suspend_control_inst (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_ctrl(ctrl), .i_cfg_we(i_cfg_we), .i_cfg_data(i_cfg_data),
        .i_pme_event(i_pme_event), .i_pme_clear(i_pme_clear), .o_status(o_status));
    // ****************************************
    // Clock, tasks and monitor
    // ****************************************
    initial
    begin
        i_clk = 1'h0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic note(input logic o, input logic f, input logic p, input logic [7:0] c);
        exp_q.push_back({o, f, p, c});
    endtask
    task automatic cmp(input rsc_pkg::rsc_status_type e);
        total_checks++;
        if (o_status !== e)
        begin
            bad_count++;
            $display("[ERR] %0t status %h expected %h", $time, o_status, e);
        end
    endtask
    // The monitor looks after the falling edge so the driver's note lands first.
    initial
    forever
    begin
        @(negedge i_clk);
        #1;
        while (exp_q.size() > 0)
            cmp(exp_q.pop_front());
    end
    initial
    begin
        #5000;
        bad_count++;
        results();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        i_rstn = 1'h0;
        i_cfg_we = 1'h0;
        i_pme_event = 1'h0;
        i_pme_clear = 1'h0;
        bad_count = 0;
        total_checks = 0;
        i_cfg_data = 8'($urandom(43115));
        cyc(20);
        i_rstn = 1'h1;
        cyc(2);
        note(1'h0, 1'h0, 1'h0, 8'h00);
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h0);
        cyc(6);
        note(1'h1, 1'h1, 1'h0, 8'h00);
        $display("test boot done");
        d = 8'($urandom);
        i_cfg_we = 1'h1;
        i_cfg_data = ~d;
        cyc(1);
        i_cfg_data = d;
        i_pme_event = 1'h1;
        i_pme_clear = 1'h1;
        cyc(1);
        i_cfg_we = 1'h0;
        i_pme_event = 1'h0;
        i_pme_clear = 1'h0;
        note(1'h1, 1'h1, 1'h1, d);
        rsc_host_model_inst.drive(1'h1, 1'h0, 1'h0);
        // Writes offered while the bus reset is low must be refused.
        i_cfg_we = 1'h1;
        i_cfg_data = ~d;
        cyc(2);
        note(1'h0, 1'h0, 1'h1, 8'h00);
        i_cfg_we = 1'h0;
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h0);
        cyc(6);
        note(1'h1, 1'h1, 1'h1, 8'h00);
        i_pme_clear = 1'h1;
        cyc(1);
        i_pme_clear = 1'h0;
        note(1'h1, 1'h1, 1'h0, 8'h00);
        $display("test bus reset done");
        i_cfg_we = 1'h1;
        i_cfg_data = d;
        i_pme_event = 1'h1;
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h1);
        i_pme_event = 1'h0;
        i_cfg_data = ~d;
        rsc_host_model_inst.drive(1'h0, 1'h0, 1'h1);
        // A clear offered while suspended must not touch the wake context.
        i_pme_clear = 1'h1;
        cyc(2);
        note(1'h0, 1'h0, 1'h1, d);
        i_cfg_we = 1'h0;
        i_pme_clear = 1'h0;
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h1);
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h0);
        cyc(6);
        note(1'h1, 1'h1, 1'h1, d);
        $display("test suspend done");
        rsc_host_model_inst.drive(1'h0, 1'h1, 1'h0);
        cyc(1);
        note(1'h0, 1'h0, 1'h0, 8'h00);
        // Releasing the cold reset under suspend must settle in suspend, not run.
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h1);
        cyc(6);
        note(1'h0, 1'h0, 1'h0, 8'h00);
        rsc_host_model_inst.drive(1'h1, 1'h1, 1'h0);
        cyc(6);
        note(1'h1, 1'h1, 1'h0, 8'h00);
        cyc(1);
        $display("test cold reset done");
        results();
    end
endmodule
